// *** include/fpl_pkg.sv ***
// package: constants and types for the flyback protection logic
package fpl_pkg;

  // ****************************************************************
  // timing figures and derived cycle counts
  // ****************************************************************
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int BLANK_TIME_PS     = 350000;                 // 350 ns blanking
  localparam int AUX_DELAY_PS      = 3000000;                // 3 us sample delay
  localparam int SCP_TIME_MS       = 16;                     // 16 ms short-circuit
  localparam int CLK_PER_MS        = 250000;
  localparam int BLANK_CYCLES      = (BLANK_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AUX_DELAY_CYCLES  = (AUX_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCP_CYCLES        = SCP_TIME_MS * CLK_PER_MS;
  localparam int OLP_TICKS         = 64;                     // timer ticks for overload delay
  localparam int OLP_SUPPLY_LOCKOUT_LEVEL_EVENTS   = 4;                      // release on 4th supply-off
  localparam int AUX_OV_CYCLES     = 4;                      // consecutive aux overvoltage cycles

  // ****************************************************************
  // variant encoding
  // ****************************************************************
  localparam logic VARIANT_AUTO    = 1'b0;
  localparam logic VARIANT_LATCH   = 1'b1;

  // ****************************************************************
  // gate state machine
  // ****************************************************************
  typedef enum logic [1:0] {
    FPL_IDLE  = 2'b00,
    FPL_ON    = 2'b01,
    FPL_OFF   = 2'b10
  } fpl_gate_t;

endpackage : fpl_pkg

// *** logic/fpl_sync.sv ***
// two-stage synchroniser for a bundle of comparator flags
`timescale 1ns/1ps
module fpl_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,  // clock
  input  wire logic         reset,     // sync reset, active high
  input  wire logic [W-1:0] async_in,  // raw levels
  output logic      [W-1:0] sync_out   // synchronised levels
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : fpl_sync

// *** logic/fpl_count.sv ***
// saturating up-counter that clears when its condition drops
`timescale 1ns/1ps
module fpl_count #(
  parameter int W = 8
) (
  input  wire logic         core_clk,  // clock
  input  wire logic         reset,     // sync reset, active high
  input  wire logic         clr,       // synchronous clear
  input  wire logic         run,       // hold condition, count while high
  input  wire logic         step,      // advance strobe
  input  wire logic [W-1:0] limit,     // terminal count
  output logic              done       // count reached limit
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (clr || !run) begin
      cnt_nxt = '0;
    end else if (step && cnt_r < limit) begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done = run && (cnt_r >= limit);
endmodule : fpl_count

// *** logic/fpl_top.sv ***
// flyback protection and gate gating logic
// Functional notes
// - end gate-on when current sense comparator reaches its limit
// - compensation source on only with feedback above 2.9V and high line
// - ignore current sense for 350ns after each gate turn-on
// - auto-recovery: gate off, short burst at each supply-on, resume when fault gone
// - latched: gate stays off until power-down reset then supply-on
// - overload trips when feedback at/above 4.2V beyond timer delay
// - overload release only at 4th supply-off event; latched variant instead holds it until power-down reset
// - short-circuit trips when feedback high over 16ms with supply below 10V
// - supply overvoltage turns gate off at once until next supply-on
// - falling edge of aux winding sense starts new gate-on
// - sample aux overvoltage comparator 3us after gate turn-off
// - aux overvoltage judged from 300uA sink comparator sample
// - four consecutive aux overvoltage cycles turn switch off
// - over-temperature disables gate, auto re-enable once flag clears
// - external fault pin below 1.25V latches shutdown
// - overload delay counted in ticks of capacitor timer oscillator
// - feedback below stop level disables gate, above start level releases
`timescale 1ns/1ps
module fpl_top
#(
  parameter int SCP_CYCLES_P = fpl_pkg::SCP_CYCLES  // short-circuit delay in clocks
) (
  input  wire logic core_clk,            // 250 MHz clock
  input  wire logic reset,               // sync reset, active high
  input  wire logic power_down_reset,    // supply below power-down level
  input  wire logic supply_on_evt,       // supply rose past lockout on level
  input  wire logic supply_off_evt,      // supply fell past lockout off level
  input  wire logic supply_below_10v,    // supply below 10 V comparator
  input  wire logic supply_ov,           // supply overvoltage comparator
  input  wire logic primary_current_sense, // current sense reached 0.65 V
  input  wire logic feedback_high,       // feedback level at or above 4.2 V
  input  wire logic feedback_comp_on,    // feedback level above 2.9 V
  input  wire logic feedback_stop,       // feedback below stop trip level
  input  wire logic feedback_start,      // feedback above start trip level
  input  wire logic high_line,           // line detector reports high line
  input  wire logic aux_winding_sense,   // aux above 0.05 V zero-crossing comparator
  input  wire logic aux_ov_current,      // aux sink current above 300 uA
  input  wire logic over_temp,           // on-chip over-temperature flag
  input  wire logic ext_fault_low,       // external fault pin below 1.25 V
  input  wire logic timer_cap_tick,      // timer capacitor oscillator tick
  input  wire logic variant_latch,       // 1: latched handling, 0: auto-recovery
  output logic      flyback_gate_drive,  // gate enable
  output logic      comp_source_en,      // current-sense offset compensation enable
  output logic      fault_latched,       // any fault, burst stop or power-down reset holding the gate off
  output logic      overload_protect,    // overload trip held
  output logic      short_circuit_protect, // short-circuit trip held
  output logic      overvoltage_protect  // supply or aux overvoltage held
);
  import fpl_pkg::*;

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  localparam int NS = 17;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] s_in;
  assign raw_in = {power_down_reset, supply_on_evt, supply_off_evt, supply_below_10v,
                   supply_ov, primary_current_sense, feedback_high, feedback_comp_on,
                   feedback_stop, feedback_start, high_line, aux_winding_sense,
                   aux_ov_current, over_temp, ext_fault_low, timer_cap_tick,
                   variant_latch};

  fpl_sync #(.W(NS)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (raw_in),
    .sync_out (s_in)
  );

  logic pdr_s, son_s, soff_s, s10_s, sov_s, cs_s, fbh_s, fbc_s;
  logic fbstop_s, fbstart_s, hl_s, aux_s, auxov_s, ot_s, ext_s, tick_s, var_s;
  assign {pdr_s, son_s, soff_s, s10_s, sov_s, cs_s, fbh_s, fbc_s, fbstop_s, fbstart_s,
          hl_s, aux_s, auxov_s, ot_s, ext_s, tick_s, var_s} = s_in;

  // ****************************************************************
  // edge detection on synchronised levels
  // ****************************************************************
  logic [3:0] dly_r, dly_nxt;  // previous aux, supply-on, supply-off, tick levels
  logic       aux_fall, son_rise, soff_rise, tick_rise;
  always_comb begin
    dly_nxt = {aux_s, son_s, soff_s, tick_s};
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dly_r <= 4'h0;
    end else begin
      dly_r <= dly_nxt;
    end
  end
  assign aux_fall  = dly_r[3] && !aux_s;
  assign son_rise  = son_s && !dly_r[2];
  assign soff_rise = soff_s && !dly_r[1];
  assign tick_rise = tick_s && !dly_r[0];

  // ****************************************************************
  // overload and short-circuit timers
  // ****************************************************************
  logic olp_done, scp_done, scp_run;
  assign scp_run = fbh_s && s10_s;

  fpl_count #(.W(8)) u_olp_cnt (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (pdr_s),
    .run      (fbh_s),
    .step     (tick_rise),
    .limit    (8'(OLP_TICKS)),
    .done     (olp_done)
  );

  fpl_count #(.W(24)) u_scp_cnt (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (pdr_s),
    .run      (scp_run),
    .step     (1'b1),
    .limit    (24'(SCP_CYCLES_P)),
    .done     (scp_done)
  );

  // ****************************************************************
  // fault latches
  // ****************************************************************
  logic olp_r, scp_r, sov_r, aov_r, ot_r, ext_r, sov_lat_r, aov_lat_r, olp_lat_r;
  logic olp_nxt, scp_nxt, sov_nxt, aov_nxt, ot_nxt, ext_nxt;
  logic sov_lat_nxt, aov_lat_nxt, olp_lat_nxt;
  logic [2:0] supply_lockout_level_cnt_r, supply_lockout_level_cnt_nxt;
  logic [2:0] aov_cnt_r, aov_cnt_nxt;
  logic aux_sample, auto_clear;

  // auto faults clear at supply-on once the cause is gone; latched wait for power-down
  assign auto_clear = son_rise;

  always_comb begin
    olp_nxt      = olp_r;
    scp_nxt      = scp_r;
    sov_nxt      = sov_r;
    aov_nxt      = aov_r;
    ot_nxt       = ot_s;
    ext_nxt      = ext_r;
    sov_lat_nxt  = sov_lat_r;
    aov_lat_nxt  = aov_lat_r;
    olp_lat_nxt  = olp_lat_r;
    supply_lockout_level_cnt_nxt = supply_lockout_level_cnt_r;
    aov_cnt_nxt  = aov_cnt_r;
    if (pdr_s) begin
      olp_nxt      = 1'b0;
      scp_nxt      = 1'b0;
      sov_nxt      = 1'b0;
      aov_nxt      = 1'b0;
      ext_nxt      = 1'b0;
      sov_lat_nxt  = 1'b0;
      aov_lat_nxt  = 1'b0;
      olp_lat_nxt  = 1'b0;
      supply_lockout_level_cnt_nxt = 3'h0;
      aov_cnt_nxt  = 3'h0;
    end else begin
      // overload: counts supply-off events, auto release on the 4th
      if (olp_r && !olp_lat_r && soff_rise) begin
        if (supply_lockout_level_cnt_r == 3'(OLP_SUPPLY_LOCKOUT_LEVEL_EVENTS - 1)) begin
          olp_nxt      = 1'b0;
          supply_lockout_level_cnt_nxt = 3'h0;
        end else begin
          supply_lockout_level_cnt_nxt = supply_lockout_level_cnt_r + 3'h1;
        end
      end
      if (olp_done) begin
        olp_nxt     = 1'b1;
        olp_lat_nxt = var_s;
      end
      // short-circuit: auto-recovery, retried at each supply-on
      if (scp_r && auto_clear) begin
        scp_nxt = 1'b0;
      end
      if (scp_done) begin
        scp_nxt = 1'b1;
      end
      // supply overvoltage: off until supply-on, latched variant waits for power-down
      if (sov_r && !sov_lat_r && auto_clear && !sov_s) begin
        sov_nxt = 1'b0;
      end
      if (sov_s) begin
        sov_nxt     = 1'b1;
        sov_lat_nxt = var_s;
      end
      // aux overvoltage: counts consecutive sampled cycles
      if (aov_r && !aov_lat_r && auto_clear) begin
        aov_nxt = 1'b0;
      end
      if (aux_sample) begin
        if (auxov_s) begin
          if (aov_cnt_r == 3'(AUX_OV_CYCLES - 1)) begin
            aov_nxt     = 1'b1;
            aov_lat_nxt = var_s;
            aov_cnt_nxt = 3'h0;
          end else begin
            aov_cnt_nxt = aov_cnt_r + 3'h1;
          end
        end else begin
          aov_cnt_nxt = 3'h0;
        end
      end
      if (ext_s) begin
        ext_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      olp_r      <= 1'b0;
      scp_r      <= 1'b0;
      sov_r      <= 1'b0;
      aov_r      <= 1'b0;
      ot_r       <= 1'b0;
      ext_r      <= 1'b0;
      sov_lat_r  <= 1'b0;
      aov_lat_r  <= 1'b0;
      olp_lat_r  <= 1'b0;
      supply_lockout_level_cnt_r <= 3'h0;
      aov_cnt_r  <= 3'h0;
    end else begin
      olp_r      <= olp_nxt;
      scp_r      <= scp_nxt;
      sov_r      <= sov_nxt;
      aov_r      <= aov_nxt;
      ot_r       <= ot_nxt;
      ext_r      <= ext_nxt;
      sov_lat_r  <= sov_lat_nxt;
      aov_lat_r  <= aov_lat_nxt;
      olp_lat_r  <= olp_lat_nxt;
      supply_lockout_level_cnt_r <= supply_lockout_level_cnt_nxt;
      aov_cnt_r  <= aov_cnt_nxt;
    end
  end

  // ****************************************************************
  // gate state machine
  // ****************************************************************
  fpl_gate_t  st_r, st_nxt;
  logic [9:0] tmr_r, tmr_nxt;
  logic       fb_en_r, fb_en_nxt;
  logic       blocked;
  logic       cs_end;

  // burst off on stop level, back on at start level
  always_comb begin
    fb_en_nxt = fb_en_r;
    if (fbstop_s) begin
      fb_en_nxt = 1'b0;
    end else if (fbstart_s) begin
      fb_en_nxt = 1'b1;
    end
  end

  assign blocked = olp_r || scp_r || sov_r || aov_r || ot_r || ext_r || !fb_en_r
                   || pdr_s;

  // blanking hides the switching spike from the limit comparator
  assign cs_end = cs_s && (tmr_r >= 10'(BLANK_CYCLES));

  always_comb begin
    st_nxt     = st_r;
    tmr_nxt    = tmr_r;
    aux_sample = 1'b0;
    case (st_r)
      FPL_IDLE: begin
        tmr_nxt = 10'h0;
        if (!blocked && aux_fall) begin
          st_nxt = FPL_ON;
        end
      end
      FPL_ON: begin
        if (tmr_r != 10'h3FF) begin
          tmr_nxt = tmr_r + 10'h1;
        end
        if (blocked || cs_end) begin
          st_nxt  = FPL_OFF;
          tmr_nxt = 10'h0;
        end
      end
      FPL_OFF: begin
        tmr_nxt = tmr_r + 10'h1;
        if (tmr_r == 10'(AUX_DELAY_CYCLES - 1)) begin
          aux_sample = 1'b1;
          st_nxt     = FPL_IDLE;
        end
      end
      default: begin
        st_nxt  = FPL_IDLE;
        tmr_nxt = 10'h0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r    <= FPL_IDLE;
      tmr_r   <= 10'h0;
      fb_en_r <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      tmr_r   <= tmr_nxt;
      fb_en_r <= fb_en_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic gate_r, gate_nxt, comp_r, comp_nxt;

  always_comb begin
    gate_nxt = (st_nxt == FPL_ON);
    comp_nxt = fbc_s && hl_s;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gate_r <= 1'b0;
      comp_r <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
      comp_r <= comp_nxt;
    end
  end

  assign flyback_gate_drive    = gate_r;
  assign comp_source_en        = comp_r;
  assign fault_latched         = blocked;
  assign overload_protect      = olp_r;
  assign short_circuit_protect = scp_r;
  assign overvoltage_protect   = sov_r || aov_r;
endmodule : fpl_top

// *** sim/fpl_props.sv ***
// checker: port-level properties of the flyback protection logic
`timescale 1ns/1ps
module fpl_props
  import fpl_pkg::*;
#(
  parameter int SCP_CYCLES_P = 100  // short-circuit delay in clocks
) (
  input wire logic core_clk,              // clock
  input wire logic reset,                 // sync reset
  input wire logic power_down_reset,      // below pdr
  input wire logic supply_on_evt,         // supply-on
  input wire logic supply_off_evt,        // supply-off
  input wire logic supply_below_10v,      // supply low
  input wire logic supply_ov,             // supply ov
  input wire logic primary_current_sense, // current limit
  input wire logic feedback_high,         // fb high
  input wire logic feedback_comp_on,      // fb above comp level
  input wire logic feedback_stop,         // fb stop
  input wire logic feedback_start,        // fb start
  input wire logic high_line,             // high line
  input wire logic aux_winding_sense,     // aux zero crossing
  input wire logic aux_ov_current,        // aux sink current
  input wire logic over_temp,             // over-temperature
  input wire logic ext_fault_low,         // external fault
  input wire logic timer_cap_tick,        // timer tick
  input wire logic variant_latch,         // variant
  input wire logic flyback_gate_drive,    // gate
  input wire logic comp_source_en,        // comp source
  input wire logic fault_latched,         // fault held
  input wire logic overload_protect,      // overload
  input wire logic short_circuit_protect, // short circuit
  input wire logic overvoltage_protect    // overvoltage
);
  logic [7:0] on_r, pc_r, ot_r, ov_r, st_r, q_r, ec_r;
  logic [7:0] on_nxt, pc_nxt, ot_nxt, ov_nxt, st_nxt, q_nxt, ec_nxt;
  logic       ex_r, ex_nxt, busy;
  // saturating run-length of a level, so long waits never wrap
  function automatic logic [7:0] up(input logic c, input logic [7:0] v);
    return c ? v + {7'h00, v != 8'hFF} : 8'h00;
  endfunction : up
  assign busy = supply_ov | over_temp | ext_fault_low | feedback_stop | power_down_reset
              | fault_latched | overload_protect | short_circuit_protect | overvoltage_protect;
  always_comb begin
    on_nxt = up(flyback_gate_drive, on_r);
    pc_nxt = up(primary_current_sense, pc_r);
    ot_nxt = up(over_temp, ot_r);
    ov_nxt = up(supply_ov, ov_r);
    st_nxt = up(feedback_stop, st_r);
    q_nxt  = up(!busy, q_r);
    ec_nxt = up(ext_fault_low, ec_r);
    ex_nxt = !power_down_reset && (ex_r || ec_r >= 8'h05);
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      {on_r, pc_r, ot_r, ov_r, st_r, q_r, ec_r} <= '0;
      ex_r <= 1'h0;
    end else begin
      {on_r, pc_r, ot_r, ov_r, st_r, q_r, ec_r} <=
        {on_nxt, pc_nxt, ot_nxt, ov_nxt, st_nxt, q_nxt, ec_nxt};
      ex_r <= ex_nxt;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  comp_on_a: assert property ((feedback_comp_on && high_line)[*5] |-> comp_source_en)
    else $error("comp source stays off");
  comp_off_a: assert property ((!(feedback_comp_on && high_line))[*5] |-> !comp_source_en)
    else $error("comp source stays on");
  cur_limit_a: assert property (!(flyback_gate_drive && on_r >= 8'd100 && pc_r >= 8'h06))
    else $error("gate not ended by current limit");
  blank_min_a: assert property ($fell(flyback_gate_drive) && q_r >= 8'h08
    |-> on_r >= BLANK_CYCLES) else $error("gate ended inside blanking");
  valley_on_a: assert property ($rose(flyback_gate_drive) |->
    !$past(aux_winding_sense, 3) || !$past(aux_winding_sense, 4) || !$past(aux_winding_sense, 5))
    else $error("gate start without aux fall");
  heat_off_a: assert property (ot_r >= 8'h05 |-> !flyback_gate_drive)
    else $error("gate on while hot");
  ov_off_a: assert property (ov_r >= 8'h05 |-> !flyback_gate_drive && overvoltage_protect)
    else $error("gate on during supply ov");
  ext_latch_a: assert property (ex_r |-> !flyback_gate_drive && fault_latched)
    else $error("external latch released early");
  stop_off_a: assert property (st_r >= 8'h05 |-> !flyback_gate_drive)
    else $error("gate on below stop level");
  olp_gate_a: assert property (overload_protect[*4] |-> !flyback_gate_drive)
    else $error("gate on during overload");
  scp_gate_a: assert property (short_circuit_protect[*4] |-> !flyback_gate_drive)
    else $error("gate on during short circuit");
  cover property ($fell(flyback_gate_drive) && q_r >= 8'h08);
  cover property ($rose(overload_protect));
  cover property ($rose(overvoltage_protect));
  cover property ($rose(short_circuit_protect));
endmodule : fpl_props

bind fpl_top fpl_props #(.SCP_CYCLES_P(SCP_CYCLES_P)) u_props (
  .core_clk(core_clk), .reset(reset), .power_down_reset(power_down_reset),
  .supply_on_evt(supply_on_evt), .supply_off_evt(supply_off_evt),
  .supply_below_10v(supply_below_10v), .supply_ov(supply_ov),
  .primary_current_sense(primary_current_sense), .feedback_high(feedback_high),
  .feedback_comp_on(feedback_comp_on), .feedback_stop(feedback_stop),
  .feedback_start(feedback_start), .high_line(high_line),
  .aux_winding_sense(aux_winding_sense), .aux_ov_current(aux_ov_current),
  .over_temp(over_temp), .ext_fault_low(ext_fault_low), .timer_cap_tick(timer_cap_tick),
  .variant_latch(variant_latch), .flyback_gate_drive(flyback_gate_drive),
  .comp_source_en(comp_source_en), .fault_latched(fault_latched),
  .overload_protect(overload_protect), .short_circuit_protect(short_circuit_protect),
  .overvoltage_protect(overvoltage_protect));

// *** sim/fpl_partner.sv ***
// partner: analog comparators around the flyback switch
`timescale 1ns/1ps
module fpl_partner (
  input  wire logic core_clk, // clock
  input  wire logic gate,     // gate enable from the block
  input  wire logic ov_on,    // bench asks for output overvoltage
  output logic      aux,      // aux winding above zero-crossing level
  output logic      pcs,      // current sense at limit
  output logic      aux_ov    // aux sink current above threshold
);
  int   t;
  int   lim;
  int   dem;
  logic g_q;
  initial begin
    {aux, pcs, aux_ov} <= 3'h0;
    g_q = 1'h0;
    t = 0;
    lim = 100;
    dem = 850;
  end
  always @(negedge core_clk) begin
    if (gate !== g_q) begin
      t = 0;
      lim = $urandom_range(150, 20);
      dem = $urandom_range(900, 800);
    end else begin
      t++;
    end
    // no restart timer in the block, so an idle switch keeps ringing to valleys
    if (!gate && t >= dem + 200)
      t = dem - 1;
    g_q = gate;
    pcs <= gate && (t < 3 || t >= lim);
    aux_ov <= !gate && (t < 100 ? t[0] : (t < dem && ov_on));
    aux <= !gate && !(t >= dem && t < dem + 20);
  end
endmodule : fpl_partner

// *** sim/testbench.sv ***
// testbench: self-checking bench for the flyback protection logic
`timescale 1ns/1ps
module testbench;
  import fpl_pkg::*;
  localparam int SCP = 200;
  logic core_clk, reset, power_down_reset, supply_on_evt, supply_off_evt, supply_below_10v;
  logic supply_ov, primary_current_sense, feedback_high, feedback_comp_on, feedback_stop;
  logic feedback_start, high_line, aux_winding_sense, aux_ov_current, over_temp;
  logic ext_fault_low, timer_cap_tick, variant_latch, ov_on;
  logic flyback_gate_drive, comp_source_en, fault_latched, overload_protect;
  logic short_circuit_protect, overvoltage_protect;
  int   n_fail, num_checks, v, i;
  fpl_top #(.SCP_CYCLES_P(SCP)) uut (
    .core_clk(core_clk), .reset(reset), .power_down_reset(power_down_reset),
    .supply_on_evt(supply_on_evt), .supply_off_evt(supply_off_evt),
    .supply_below_10v(supply_below_10v), .supply_ov(supply_ov),
    .primary_current_sense(primary_current_sense), .feedback_high(feedback_high),
    .feedback_comp_on(feedback_comp_on), .feedback_stop(feedback_stop),
    .feedback_start(feedback_start), .high_line(high_line),
    .aux_winding_sense(aux_winding_sense), .aux_ov_current(aux_ov_current),
    .over_temp(over_temp), .ext_fault_low(ext_fault_low), .timer_cap_tick(timer_cap_tick),
    .variant_latch(variant_latch), .flyback_gate_drive(flyback_gate_drive),
    .comp_source_en(comp_source_en), .fault_latched(fault_latched),
    .overload_protect(overload_protect), .short_circuit_protect(short_circuit_protect),
    .overvoltage_protect(overvoltage_protect));
  fpl_partner pm (.core_clk(core_clk), .gate(flyback_gate_drive), .ov_on(ov_on),
    .aux(aux_winding_sense), .pcs(primary_current_sense), .aux_ov(aux_ov_current));
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // waits for the gate to leave and then reach the level, bounded
  task automatic wait_gate(input logic lvl);
    int k;
    k = 0;
    while (flyback_gate_drive !== !lvl && k < 9000) begin
      cyc(1);
      k++;
    end
    while (flyback_gate_drive !== lvl && k < 9000) begin
      cyc(1);
      k++;
    end
    chk(k < 9000, 1'h1);
  endtask : wait_gate
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(6);
    s = 1'h0;
    cyc(6);
  endtask : pulse
  task automatic tick(input int n);
    repeat (n) begin
      timer_cap_tick = 1'h1;
      cyc(4);
      timer_cap_tick = 1'h0;
      cyc(4);
    end
  endtask : tick
  task automatic power_cycle;
    power_down_reset = 1'h1;
    cyc(8);
    power_down_reset = 1'h0;
    cyc(4);
    pulse(supply_on_evt);
  endtask : power_cycle
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    #400000;
    n_fail++;
    end_sim();
  end
  initial begin
    {power_down_reset, supply_on_evt, supply_off_evt, supply_below_10v, supply_ov} = '0;
    {feedback_high, feedback_comp_on, feedback_stop, feedback_start, high_line} = '0;
    {over_temp, ext_fault_low, timer_cap_tick, variant_latch, ov_on} = '0;
    n_fail = 0;
    num_checks = 0;
    reset = 1'h1;
    v = $urandom(32'hB6E81DA3);
    cyc(16);
    reset = 1'h0;
    // ****************************************************************
    // switching, compensation source, aux overvoltage filter
    // ****************************************************************
    for (i = 0; i < 6; i++)
      wait_gate(1'h1);
    chk(overvoltage_protect, 1'h0);
    for (i = 0; i < 12; i++) begin
      {feedback_comp_on, high_line} = (i < 4) ? i[1:0] : 2'($urandom);
      cyc(6);
      chk(comp_source_en, feedback_comp_on & high_line);
    end
    for (v = 0; v < 2; v++) begin
      variant_latch = v[0];
      wait_gate(1'h1);
      ov_on = 1'h1;
      repeat (3) wait_gate(1'h0);
      cyc(800);
      chk(overvoltage_protect, 1'h0);
      wait_gate(1'h0);
      cyc(800);
      chk(overvoltage_protect, 1'h1);
      ov_on = 1'h0;
      pulse(supply_on_evt);
      chk(overvoltage_protect, v[0]);
      if (!v[0])
        wait_gate(1'h1);
      power_cycle();
      chk(fault_latched, 1'h0);
      // overload: one tick short of the limit, then one past it; 4th supply-off releases auto, latched holds
      feedback_high = 1'h1;
      cyc(4);
      tick(OLP_TICKS - 1);
      chk(overload_protect, 1'h0);
      tick(2);
      chk(overload_protect, 1'h1);
      feedback_high = 1'h0;
      repeat (OLP_SUPPLY_LOCKOUT_LEVEL_EVENTS - 1) pulse(supply_off_evt);
      chk(overload_protect, 1'h1);
      pulse(supply_off_evt);
      chk(overload_protect, v[0]);
      power_cycle();
      chk(overload_protect, 1'h0);
    end
    // ****************************************************************
    // short circuit, simple faults, external latch, mid-run reset
    // ****************************************************************
    variant_latch = 1'h0;
    feedback_high = 1'h1;
    cyc(SCP + 20);
    chk(short_circuit_protect, 1'h0);
    supply_below_10v = 1'h1;
    cyc(SCP - 4);
    chk(short_circuit_protect, 1'h0);
    cyc(12);
    chk(short_circuit_protect, 1'h1);
    {feedback_high, supply_below_10v} = 2'h0;
    pulse(supply_on_evt);
    chk(short_circuit_protect, 1'h0);
    for (i = 0; i < 3; i++) begin
      wait_gate(1'h1);
      {feedback_stop, supply_ov, over_temp} = 3'(1 << i);
      cyc(8);
      chk(flyback_gate_drive, 1'h0);
      chk(overvoltage_protect, i == 1);
      {feedback_stop, supply_ov, over_temp} = 3'h0;
      feedback_start = (i == 2);
      if (i == 1) begin
        cyc(1500);
        chk(flyback_gate_drive, 1'h0);
        pulse(supply_on_evt);
      end
      wait_gate(1'h1);
      feedback_start = 1'h0;
    end
    ext_fault_low = 1'h1;
    cyc(8);
    chk(fault_latched, 1'h1);
    ext_fault_low = 1'h0;
    pulse(supply_on_evt);
    cyc(1500);
    chk(flyback_gate_drive, 1'h0);
    power_cycle();
    wait_gate(1'h1);
    {feedback_high, supply_below_10v} = 2'h3;
    cyc(SCP + 20);
    reset = 1'h1;
    cyc(2);
    reset = 1'h0;
    cyc(1);
    chk({short_circuit_protect, fault_latched, flyback_gate_drive}, 3'h0);
    end_sim();
  end
endmodule : testbench
